// [logic/iefl_consts.vh]
`ifndef IEFL_CONSTS_VH
`define IEFL_CONSTS_VH

// register port geometry
`define IEFL_ADDR_W          3
`define IEFL_DATA_W          8

// register offsets
`define IEFL_OFF_CONTROL     3'h0
`define IEFL_OFF_PERIPH      3'h1
`define IEFL_OFF_EDGE_CFG    3'h2
`define IEFL_OFF_PC_FLAGS    3'h3

// irq_control_reg field positions
`define IEFL_CTL_GLOBAL      7
`define IEFL_CTL_GROUP       6
`define IEFL_CTL_T0IE        5
`define IEFL_CTL_EXTIE       4
`define IEFL_CTL_PCIE        3
`define IEFL_CTL_T0IF        2
`define IEFL_CTL_EXTIF       1
`define IEFL_CTL_PCIF        0

// periph_irq_enable_reg1 field positions
`define IEFL_PIE_T1GATE      7
`define IEFL_PIE_ADC         6
`define IEFL_PIE_SRX         5
`define IEFL_PIE_STX         4
`define IEFL_PIE_SSP         3
`define IEFL_PIE_CAPCMP      2
`define IEFL_PIE_T2          1
`define IEFL_PIE_T1OVF       0

// edge configuration field position
`define IEFL_EDGE_SEL        0

// reset values
`define IEFL_RST_BYTE        8'h00
`define IEFL_RST_BIT         1'b0

// vector loaded on acceptance
`define IEFL_VEC_W           16
`define IEFL_VECTOR          16'h0004

// monitored pin-change inputs
`define IEFL_PC_W            8

`endif

// [logic/iefl_pin_sync.v]
`include "iefl_consts.vh"
`default_nettype none

module iefl_pin_sync #(
   parameter WIDTH = 1
) (
   // clock and reset
   input  wire             mclk_in,
   input  wire             rst_n_in,
   // raw pins
   input  wire [WIDTH-1:0] pin_in,
   // filtered levels
   output reg  [WIDTH-1:0] level_out,
   output reg              valid_out
);

   reg [WIDTH-1:0] stage1_q;
   reg [WIDTH-1:0] stage2_q;
   reg [WIDTH-1:0] stage3_q;
   reg [2:0]       fill_q;

   // stage1 feeds only stage2; a bit moves only once stage2 and stage3 agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               stage1_q[i]  <= 1'b0;
               stage2_q[i]  <= 1'b0;
               stage3_q[i]  <= 1'b0;
               level_out[i] <= 1'b0;
            end else begin
               stage1_q[i] <= pin_in[i];
               stage2_q[i] <= stage1_q[i];
               stage3_q[i] <= stage2_q[i];
               if (stage2_q[i] == stage3_q[i]) begin
                  level_out[i] <= stage3_q[i];
               end
            end
         end
      end
   endgenerate

   // valid only once level holds the settled pin, so a pin idling high is no edge
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fill_q    <= 3'h0;
         valid_out <= 1'b0;
      end else begin
         fill_q    <= {fill_q[1:0], 1'b1};
         valid_out <= fill_q[2];
      end
   end

endmodule // iefl_pin_sync

`default_nettype wire

// [logic/iefl_core.v]
// Notes on behaviour
// - global enable gates every request to core
// - peripheral group enable masks all peripheral sources
// - timer0 overflow forwarded only when enabled
// - external pin flag forwarded only when enabled
// - pin-change flag forwarded only when enabled
// - timer0 overflow sets its flag
// - external pin event sets its flag
// - pin-change flag reads one while pins changed
// - all register bits clear on reset
// - timer1 gate enable lets gate event request
// - adc enable lets conversion done request
// - serial receive enable lets receive event request
// - serial transmit enable lets transmit event request
// - sync serial enable lets port event request
// - capture compare enable lets unit request
// - timer1 overflow enable lets overflow request
// - flags set regardless of any enable
// - acceptance clears global enable, loads vector
// - edge select picks rising or falling edge
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`include "iefl_consts.vh"
`default_nettype none

module iefl_core (
   // clock and reset
   input  wire                       mclk_in,
   input  wire                       rst_n_in,
   // register port
   input  wire [`IEFL_ADDR_W-1:0]    addr_in,
   input  wire [`IEFL_DATA_W-1:0]    wdata_in,
   input  wire                       wr_in,
   input  wire                       rd_in,
   output reg  [`IEFL_DATA_W-1:0]    rdata_out,
   // event sources, same clock
   input  wire                       timer0_ovf_in,
   input  wire [7:0]                 periph_flags_in,
   // event sources, pins
   input  wire                       ext_pin_in,
   input  wire [`IEFL_PC_W-1:0]      pin_change_in,
   // processor core
   input  wire                       irq_ack_in,
   input  wire                       irq_return_in,
   output reg                        irq_req_out,
   output reg                        vector_load_out,
   output reg  [`IEFL_VEC_W-1:0]     vector_addr_out
);

   // register state
   reg                    global_irq_enable_q;
   reg                    global_irq_enable_d;
   reg                    peripheral_irq_enable_q;
   reg                    timer0_ovf_irq_enable_q;
   reg                    ext_pin_irq_enable_q;
   reg                    pin_change_irq_enable_q;
   reg                    timer0_ovf_flag_q;
   reg                    timer0_ovf_flag_d;
   reg                    ext_pin_flag_q;
   reg                    ext_pin_flag_d;
   reg  [7:0]             periph_irq_enable_reg1_q;
   reg                    ext_edge_select_q;
   reg  [`IEFL_PC_W-1:0]  pc_flags_q;

   // pin tracking
   wire                   ext_level;
   wire                   ext_valid;
   wire [`IEFL_PC_W-1:0]  pc_level;
   wire                   pc_valid;
   reg                    ext_prev_q;
   reg  [`IEFL_PC_W-1:0]  pc_prev_q;
   reg                    armed_q;

   // decode
   wire                   wr_ctl;
   wire                   wr_pie;
   wire                   wr_edge;
   wire                   wr_pcf;
   wire                   ext_rise;
   wire                   ext_fall;
   wire                   ext_event;
   wire [`IEFL_PC_W-1:0]  pc_change;
   wire                   pin_change_flag;
   wire [7:0]             control_view;
   wire                   core_pending;
   wire                   periph_pending;
   wire                   req_d;
   wire                   accept;
   reg  [`IEFL_DATA_W-1:0] rdata_d;

   assign wr_ctl  = wr_in && (addr_in == `IEFL_OFF_CONTROL);
   assign wr_pie  = wr_in && (addr_in == `IEFL_OFF_PERIPH);
   assign wr_edge = wr_in && (addr_in == `IEFL_OFF_EDGE_CFG);
   assign wr_pcf  = wr_in && (addr_in == `IEFL_OFF_PC_FLAGS);

   // pins cross into the clock domain through three stages
   iefl_pin_sync #(
      .WIDTH     (1)
   ) u_ext_sync (
      .mclk_in   (mclk_in),
      .rst_n_in  (rst_n_in),
      .pin_in    (ext_pin_in),
      .level_out (ext_level),
      .valid_out (ext_valid)
   );

   iefl_pin_sync #(
      .WIDTH     (`IEFL_PC_W)
   ) u_pc_sync (
      .mclk_in   (mclk_in),
      .rst_n_in  (rst_n_in),
      .pin_in    (pin_change_in),
      .level_out (pc_level),
      .valid_out (pc_valid)
   );

   // edges are only trusted once the filtered levels are settled
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ext_prev_q <= 1'b0;
         pc_prev_q  <= {`IEFL_PC_W{1'b0}};
         armed_q    <= 1'b0;
      end else begin
         ext_prev_q <= ext_level;
         pc_prev_q  <= pc_level;
         armed_q    <= ext_valid & pc_valid;
      end
   end

   assign ext_rise  = armed_q & ext_level & ~ext_prev_q;
   assign ext_fall  = armed_q & ~ext_level & ext_prev_q;
   assign ext_event = ext_edge_select_q ? ext_rise : ext_fall;

   assign pc_change = {`IEFL_PC_W{armed_q}} & (pc_level ^ pc_prev_q);

   assign accept = irq_ack_in & irq_req_out & global_irq_enable_q;

   // global enable: acceptance clears it ahead of a same-cycle software write
   always @* begin
      global_irq_enable_d = global_irq_enable_q;
      if (wr_ctl) begin
         global_irq_enable_d = wdata_in[`IEFL_CTL_GLOBAL];
      end
      if (irq_return_in) begin
         global_irq_enable_d = 1'b1;
      end
      if (accept) begin
         global_irq_enable_d = 1'b0;
      end
   end

   // software may set or clear a flag, but a new event in that cycle still wins
   always @* begin
      timer0_ovf_flag_d = timer0_ovf_flag_q;
      ext_pin_flag_d    = ext_pin_flag_q;
      if (wr_ctl) begin
         timer0_ovf_flag_d = wdata_in[`IEFL_CTL_T0IF];
         ext_pin_flag_d    = wdata_in[`IEFL_CTL_EXTIF];
      end
      if (timer0_ovf_in) begin
         timer0_ovf_flag_d = 1'b1;
      end
      if (ext_event) begin
         ext_pin_flag_d = 1'b1;
      end
   end

   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         global_irq_enable_q      <= `IEFL_RST_BIT;
         peripheral_irq_enable_q  <= `IEFL_RST_BIT;
         timer0_ovf_irq_enable_q  <= `IEFL_RST_BIT;
         ext_pin_irq_enable_q     <= `IEFL_RST_BIT;
         pin_change_irq_enable_q  <= `IEFL_RST_BIT;
         timer0_ovf_flag_q        <= `IEFL_RST_BIT;
         ext_pin_flag_q           <= `IEFL_RST_BIT;
         periph_irq_enable_reg1_q <= `IEFL_RST_BYTE;
         ext_edge_select_q        <= `IEFL_RST_BIT;
      end else begin
         global_irq_enable_q <= global_irq_enable_d;
         timer0_ovf_flag_q   <= timer0_ovf_flag_d;
         ext_pin_flag_q      <= ext_pin_flag_d;
         if (wr_ctl) begin
            peripheral_irq_enable_q <= wdata_in[`IEFL_CTL_GROUP];
            timer0_ovf_irq_enable_q <= wdata_in[`IEFL_CTL_T0IE];
            ext_pin_irq_enable_q    <= wdata_in[`IEFL_CTL_EXTIE];
            pin_change_irq_enable_q <= wdata_in[`IEFL_CTL_PCIE];
         end
         if (wr_pie) begin
            periph_irq_enable_reg1_q <= wdata_in;
         end
         if (wr_edge) begin
            ext_edge_select_q <= wdata_in[`IEFL_EDGE_SEL];
         end
      end
   end

   // per-pin change flags, cleared by writing zero, a change in the same cycle wins
   genvar i;
   generate
      for (i = 0; i < `IEFL_PC_W; i = i + 1) begin : g_pc
         always @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               pc_flags_q[i] <= `IEFL_RST_BIT;
            end else if (pc_change[i]) begin
               pc_flags_q[i] <= 1'b1;
            end else if (wr_pcf && !wdata_in[i]) begin
               pc_flags_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign pin_change_flag = |pc_flags_q;

   assign control_view = {global_irq_enable_q,
                          peripheral_irq_enable_q,
                          timer0_ovf_irq_enable_q,
                          ext_pin_irq_enable_q,
                          pin_change_irq_enable_q,
                          timer0_ovf_flag_q,
                          ext_pin_flag_q,
                          pin_change_flag};

   assign core_pending = (timer0_ovf_flag_q & timer0_ovf_irq_enable_q)
                       | (ext_pin_flag_q & ext_pin_irq_enable_q)
                       | (pin_change_flag & pin_change_irq_enable_q);

   // timer1 gate, adc, serial receive, serial transmit, sync serial, capture compare
   // timer2, timer1 overflow, each flag ANDed with its own enable
   // group enable over all of them
   assign periph_pending = peripheral_irq_enable_q & (|(periph_flags_in & periph_irq_enable_reg1_q));

   assign req_d = global_irq_enable_d & (core_pending | periph_pending);

   // read data only in the cycle after the strobe; unmapped offsets read zero
   always @* begin
      rdata_d = {`IEFL_DATA_W{1'b0}};
      if (rd_in) begin
         case (addr_in)
            `IEFL_OFF_CONTROL:  rdata_d = control_view;
            `IEFL_OFF_PERIPH:   rdata_d = periph_irq_enable_reg1_q;
            `IEFL_OFF_EDGE_CFG: rdata_d = {7'h00, ext_edge_select_q};
            `IEFL_OFF_PC_FLAGS: rdata_d = pc_flags_q;
            default:            rdata_d = {`IEFL_DATA_W{1'b0}};
         endcase
      end
   end

   // outputs straight from flops; request drops in the cycle after acceptance
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out       <= `IEFL_RST_BYTE;
         irq_req_out     <= 1'b0;
         vector_load_out <= 1'b0;
         vector_addr_out <= `IEFL_VECTOR;
      end else begin
         rdata_out       <= rdata_d;
         irq_req_out     <= req_d;
         vector_load_out <= accept;
         vector_addr_out <= `IEFL_VECTOR;
      end
   end

endmodule // iefl_core

`default_nettype wire

// [verification/iefl_core_properties.sv]
`default_nettype none
module iefl_core_properties (
   input wire logic        mclk_in,
   input wire logic        rst_n_in,
   input wire logic [2:0]  addr_in,
   input wire logic [7:0]  wdata_in,
   input wire logic        wr_in,
   input wire logic [7:0]  rdata_out,
   input wire logic        timer0_ovf_in,
   input wire logic [7:0]  periph_flags_in,
   input wire logic        irq_ack_in,
   input wire logic        irq_return_in,
   input wire logic        irq_req_out,
   input wire logic        vector_load_out,
   input wire logic [15:0] vector_addr_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:3] ctl_q;
   logic [7:0] pie_q;
   wire logic  accept;
   assign accept = irq_ack_in && irq_req_out;
   // shadow enables; ack wins over write and return
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctl_q <= 5'h00;
         pie_q <= 8'h00;
      end else begin
         if (wr_in && addr_in == 3'h1) pie_q <= wdata_in;
         if (accept) ctl_q <= {1'b0, (wr_in && addr_in == 3'h0) ? wdata_in[6:3] : ctl_q[6:3]};
         else if (irq_return_in) ctl_q <= {1'b1, (wr_in && addr_in == 3'h0) ? wdata_in[6:3] : ctl_q[6:3]};
         else if (wr_in && addr_in == 3'h0) ctl_q <= wdata_in[7:3];
      end
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   property p_ack_vec; accept |=> vector_load_out && !irq_req_out; endproperty
   a_ack_vec: assert property (p_ack_vec) else $error("no vector load after accept");
   property p_vec_once; vector_load_out |=> !vector_load_out; endproperty
   a_vec_once: assert property (p_vec_once) else $error("vector load too long");
   property p_no_vec; !accept |=> !vector_load_out; endproperty
   a_no_vec: assert property (p_no_vec) else $error("vector load without accept");
   property p_vec_addr; vector_addr_out == 16'h0004; endproperty
   a_vec_addr: assert property (p_vec_addr) else $error("wrong vector address");
   property p_global_gate; !ctl_q[7] |-> !irq_req_out; endproperty
   a_global_gate: assert property (p_global_gate) else $error("request with global enable off");
   property p_core_mask; (ctl_q[6:3] == 4'h0) [*2] |-> !irq_req_out; endproperty
   a_core_mask: assert property (p_core_mask) else $error("request with all sources masked");
   property p_periph;
      ctl_q[7] && ctl_q[6] && |(pie_q & periph_flags_in) && !wr_in && !irq_ack_in |-> ##[1:2] irq_req_out;
   endproperty
   a_periph: assert property (p_periph) else $error("enabled peripheral not requested");
   property p_t0;
      (ctl_q[7] && ctl_q[5] && timer0_ovf_in && !wr_in && !irq_ack_in) ##1 (!wr_in && !irq_ack_in)
         |=> irq_req_out;
   endproperty
   a_t0: assert property (p_t0) else $error("timer0 overflow not requested");
   property p_reset; $rose(rst_n_in) |-> !irq_req_out && rdata_out == 8'h00; endproperty
   a_reset: assert property (p_reset) else $error("outputs not clear after reset");
endmodule // iefl_core_properties
`default_nettype wire

// [verification/iefl_core_model.sv]
`default_nettype none
module iefl_core_model (
   input  wire logic       mclk_in,
   input  wire logic       rst_n_in,
   input  wire logic       en_in,
   input  wire logic [3:0] delay_in,
   input  wire logic       irq_req_in,
   input  wire logic       vector_load_in,
   output var  logic       irq_ack_out,
   output var  logic       irq_return_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_q;
   logic [2:0] ret_q;
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wait_q <= 4'h0;
         ret_q <= 3'h0;
         irq_ack_out <= 1'b0;
         irq_return_out <= 1'b0;
      end else begin
         irq_ack_out <= en_in && irq_req_in && wait_q == delay_in && !irq_ack_out;
         wait_q <= (en_in && irq_req_in && wait_q != delay_in) ? wait_q + 4'h1 : 4'h0;
         ret_q <= vector_load_in ? 3'h1 : (ret_q != 3'h0 ? ret_q + 3'h1 : 3'h0);
         irq_return_out <= ret_q == 3'h3;
      end
   end
endmodule // iefl_core_model
`default_nettype wire

// [verification/test_iefl_core.sv]
`default_nettype none
module test_iefl_core;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic [2:0]  addr_in = 3'h0;
   logic [7:0]  wdata_in = 8'h00, pf = 8'h00, pc = 8'h00, r, rdata_out;
   logic        wr_in = 1'b0, rd_in = 1'b0, t0 = 1'b0, ext = 1'b0, en = 1'b0;
   logic        ack, ret, irq_req_out, vector_load_out;
   logic [3:0]  dly = 4'h0;
   logic [15:0] vec;
   int          err_total = 0, compares = 0, i;
   initial begin
      forever #12.5 mclk_in = ~mclk_in;
   end
   iefl_core u_iefl_core (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .timer0_ovf_in(t0), .periph_flags_in(pf),
      .ext_pin_in(ext), .pin_change_in(pc), .irq_ack_in(ack), .irq_return_in(ret),
      .irq_req_out(irq_req_out), .vector_load_out(vector_load_out), .vector_addr_out(vec));
   iefl_core_model u_iefl_core_model (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .en_in(en), .delay_in(dly),
      .irq_req_in(irq_req_out), .vector_load_in(vector_load_out), .irq_ack_out(ack), .irq_return_out(ret));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, exp);
   endtask
   // pin paths need the sync chain to settle before a flag shows
   task automatic settle;
      repeat (8) @(posedge mclk_in);
   endtask
   task automatic test_done;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #500000;
      err_total++;
      test_done();
   end
   initial begin
      i = $urandom(32'hd902);
      repeat (8) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      for (i = 0; i < 8; i++) rd(i[2:0], 8'h00);
      for (i = 0; i < 8; i++) begin
         r = 8'($urandom);
         wr(3'h1, r);
         rd(3'h1, r);
         wr(3'h0, r);
         rd(3'h0, r & 8'hfe);
      end
      wr(3'h0, 8'h00);
      @(posedge mclk_in) t0 <= 1'b1;
      @(posedge mclk_in) t0 <= 1'b0;
      rd(3'h0, 8'h04);
      chk({7'h0, irq_req_out}, 8'h00);
      wr(3'h0, 8'h84);
      @(posedge mclk_in) #1 chk({7'h0, irq_req_out}, 8'h00);
      wr(3'h0, 8'ha4);
      @(posedge mclk_in) #1 chk({7'h0, irq_req_out}, 8'h01);
      wr(3'h0, 8'h00);
      rd(3'h0, 8'h00);
      for (i = 0; i < 2; i++) begin
         wr(3'h2, i[7:0]);
         @(posedge mclk_in) ext <= ~i[0];
         settle();
         rd(3'h0, 8'h00);
         @(posedge mclk_in) ext <= i[0];
         settle();
         rd(3'h0, 8'h02);
         wr(3'h0, 8'h82);
         @(posedge mclk_in) #1 chk({7'h0, irq_req_out}, 8'h00);
         wr(3'h0, 8'h92);
         @(posedge mclk_in) #1 chk({7'h0, irq_req_out}, 8'h01);
         wr(3'h0, 8'h00);
      end
      i = $urandom_range(7);
      @(posedge mclk_in) pc <= 8'h01 << i;
      settle();
      rd(3'h3, 8'h01 << i);
      wr(3'h0, 8'h00);
      rd(3'h0, 8'h01);
      wr(3'h0, 8'h80);
      @(posedge mclk_in) #1 chk({7'h0, irq_req_out}, 8'h00);
      wr(3'h0, 8'h88);
      @(posedge mclk_in) #1 chk({7'h0, irq_req_out}, 8'h01);
      wr(3'h0, 8'h00);
      wr(3'h3, 8'h00);
      rd(3'h0, 8'h00);
      wr(3'h0, 8'hc0);
      for (i = 0; i < 8; i++) begin
         wr(3'h1, 8'h01 << i);
         @(posedge mclk_in) pf <= 8'($urandom) | (8'h01 << i);
         repeat (3) @(posedge mclk_in);
         #1 chk({7'h0, irq_req_out}, 8'h01);
         @(posedge mclk_in) pf <= 8'($urandom) & ~(8'h01 << i);
         repeat (3) @(posedge mclk_in);
         #1 chk({7'h0, irq_req_out}, 8'h00);
      end
      @(posedge mclk_in) pf <= 8'hff;
      wr(3'h1, 8'hff);
      wr(3'h0, 8'h80);
      repeat (3) @(posedge mclk_in);
      #1 chk({7'h0, irq_req_out}, 8'h00);
      wr(3'h0, 8'h40);
      repeat (3) @(posedge mclk_in);
      #1 chk({7'h0, irq_req_out}, 8'h00);
      @(posedge mclk_in) pf <= 8'h00;
      dly <= 4'($urandom_range(7));
      en <= 1'b1;
      wr(3'h0, 8'ha0);
      @(posedge mclk_in) t0 <= 1'b1;
      @(posedge mclk_in) t0 <= 1'b0;
      i = 0;
      while (vector_load_out !== 1'b1 && i < 40) begin
         @(posedge mclk_in);
         #1 i++;
      end
      chk({7'h0, vector_load_out}, 8'h01);
      chk(vec[15:8], 8'h00);
      chk(vec[7:0], 8'h04);
      en <= 1'b0;
      rd(3'h0, 8'h24);
      wr(3'h0, 8'h20);
      settle();
      rd(3'h0, 8'ha0);
      test_done();
   end
endmodule // test_iefl_core
bind iefl_core iefl_core_properties u_iefl_core_properties (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rdata_out(rdata_out),
   .timer0_ovf_in(timer0_ovf_in), .periph_flags_in(periph_flags_in), .irq_ack_in(irq_ack_in),
   .irq_return_in(irq_return_in), .irq_req_out(irq_req_out), .vector_load_out(vector_load_out),
   .vector_addr_out(vector_addr_out));
`default_nettype wire
